// *** verilog/brof_map.svh ***
`ifndef BROF_MAP_SVH
`define BROF_MAP_SVH
// Summary of operation
// - Byte mode decodes each code group to byte
// - Single-rate byte mode error flag high on errors
// - Outputs timed to selected output clock
// - Valid high; special and comma mark groups
// - Decoder and overrun errors give fixed codes
// - Word alignment search reports code 0x01
// - Byte alignment search reports code 0x00
// - Only highest ranked coincident condition reported
// - Single-rate byte mode never drives error low with valid low
// - Ten-bit mode bypasses the decoder
// - Bit 9 error, bit 8 valid, rest data
// - Comma flag marks the six comma code groups
// - Ten-bit errors flagged on special line
// - Double rate behaves as single rate otherwise
// - Double rate byte split across clock phases
// - Double rate ten-bit split across clock phases
// - Recovered select makes output follow link clock
// ==========================================
// Register offsets and reset values
`define BROF_CTRL_OFF 12'h000
`define BROF_STAT_OFF 12'h004
`define BROF_MASK_OFF 12'h008
`define BROF_LAST_OFF 12'h00c
`define BROF_CTRL_RST 5'h18
// ==========================================
// Error and status codes on the data lines
`define BROF_ERR_DISP 8'h10
`define BROF_ERR_CODE 8'h08
`define BROF_ERR_OVR 8'h04
`define BROF_ERR_UND 8'h02
`define BROF_ERR_WSYNC 8'h01
`define BROF_ERR_BSYNC 8'h00
// ==========================================
// Output clock lag behind the selected link clock, in pclk cycles
`define BROF_RCLK_LAG 3
`endif

// *** verilog/brof_pkg.sv ***
`default_nettype none
package brof_pkg;
  typedef struct packed {
    logic enable;
    logic rec_sel;
    logic ddr;
    logic eth;
    logic tbs;
  } brof_ctrl_t;
  typedef struct packed {
    logic disp;
    logic code;
    logic und;
    logic ovr;
    logic wsync;
    logic bsync;
  } brof_evt_t;
  typedef struct packed {
    logic err;
    logic dv;
    logic k;
    logic comma;
    logic [7:0] data;
  } brof_word_t;
  typedef struct packed {
    logic [9:0] code;
    logic bsync;
    logic wsync;
    logic ovr;
    logic und;
  } brof_grp_t;
  typedef enum logic [2:0] {
    BROF_PH_IDLE = 3'b001,
    BROF_PH_RISE = 3'b010,
    BROF_PH_FALL = 3'b100
  } brof_phase_t;
endpackage
`default_nettype wire

// *** verilog/brof_formatter.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "brof_map.svh"
module brof_formatter
  import brof_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic rx_rec_clk,
  input wire logic rx_ref_clk,
  input wire logic [9:0] rx_code_group,
  input wire logic rx_byte_sync,
  input wire logic rx_word_sync,
  input wire logic rx_overrun,
  input wire logic rx_underrun,
  output logic rx_output_clock,
  output logic rx_error_flag,
  output logic rx_valid_flag,
  output logic rx_special_flag,
  output logic rx_comma_flag,
  output logic [7:0] rx_data_lines
);

  // ==========================================
  // Decoder tables
  function automatic logic [5:0] dec6(input logic [5:0] c);
    case (c)
      6'b100111, 6'b011000: dec6 = {1'b1, 5'd0};
      6'b011101, 6'b100010: dec6 = {1'b1, 5'd1};
      6'b101101, 6'b010010: dec6 = {1'b1, 5'd2};
      6'b110001: dec6 = {1'b1, 5'd3};
      6'b110101, 6'b001010: dec6 = {1'b1, 5'd4};
      6'b101001: dec6 = {1'b1, 5'd5};
      6'b011001: dec6 = {1'b1, 5'd6};
      6'b111000, 6'b000111: dec6 = {1'b1, 5'd7};
      6'b111001, 6'b000110: dec6 = {1'b1, 5'd8};
      6'b100101: dec6 = {1'b1, 5'd9};
      6'b010101: dec6 = {1'b1, 5'd10};
      6'b110100: dec6 = {1'b1, 5'd11};
      6'b001101: dec6 = {1'b1, 5'd12};
      6'b101100: dec6 = {1'b1, 5'd13};
      6'b011100: dec6 = {1'b1, 5'd14};
      6'b010111, 6'b101000: dec6 = {1'b1, 5'd15};
      6'b011011, 6'b100100: dec6 = {1'b1, 5'd16};
      6'b100011: dec6 = {1'b1, 5'd17};
      6'b010011: dec6 = {1'b1, 5'd18};
      6'b110010: dec6 = {1'b1, 5'd19};
      6'b001011: dec6 = {1'b1, 5'd20};
      6'b101010: dec6 = {1'b1, 5'd21};
      6'b011010: dec6 = {1'b1, 5'd22};
      6'b111010, 6'b000101: dec6 = {1'b1, 5'd23};
      6'b110011, 6'b001100: dec6 = {1'b1, 5'd24};
      6'b100110: dec6 = {1'b1, 5'd25};
      6'b010110: dec6 = {1'b1, 5'd26};
      6'b110110, 6'b001001: dec6 = {1'b1, 5'd27};
      6'b001110, 6'b001111, 6'b110000: dec6 = {1'b1, 5'd28};
      6'b101110, 6'b010001: dec6 = {1'b1, 5'd29};
      6'b011110, 6'b100001: dec6 = {1'b1, 5'd30};
      6'b101011, 6'b010100: dec6 = {1'b1, 5'd31};
      default: dec6 = 6'h00;
    endcase
  endfunction

  function automatic logic [3:0] dec4(input logic [3:0] c);
    case (c)
      4'b1011, 4'b0100: dec4 = {1'b1, 3'd0};
      4'b1001: dec4 = {1'b1, 3'd1};
      4'b0101: dec4 = {1'b1, 3'd2};
      4'b1100, 4'b0011: dec4 = {1'b1, 3'd3};
      4'b1101, 4'b0010: dec4 = {1'b1, 3'd4};
      4'b1010: dec4 = {1'b1, 3'd5};
      4'b0110: dec4 = {1'b1, 3'd6};
      4'b1110, 4'b0001, 4'b0111, 4'b1000: dec4 = {1'b1, 3'd7};
      default: dec4 = 4'h0;
    endcase
  endfunction

  // ==========================================
  // Register file state
  brof_ctrl_t ctrl_q;
  brof_evt_t stat_q, mask_q, evt_d;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q;
  logic wr_acc;

  // ==========================================
  // Pin synchronisers and link clock edges
  logic [15:0] sync1_q, sync2_q;
  logic [1:0] clk_prev_q;
  logic rec_rise, sel_lvl, sel_prev, sel_rise, sel_fall;
  logic [`BROF_RCLK_LAG-1:0] lag_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end else begin
      sync1_q <= {rx_rec_clk, rx_ref_clk, rx_code_group, rx_byte_sync, rx_word_sync,
                  rx_overrun, rx_underrun};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_q <= 2'b00;
    end else begin
      clk_prev_q <= sync2_q[15:14];
    end
  end

  assign rec_rise = sync2_q[15] & ~clk_prev_q[1];
  assign sel_lvl = ctrl_q.rec_sel ? sync2_q[15] : sync2_q[14];
  assign sel_prev = ctrl_q.rec_sel ? clk_prev_q[1] : clk_prev_q[0];
  assign sel_rise = sel_lvl & ~sel_prev;
  assign sel_fall = ~sel_lvl & sel_prev;

  // Output clock trails the data so the host sees settled lines at its edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lag_q <= '0;
    end else begin
      lag_q <= {lag_q[`BROF_RCLK_LAG-2:0], sel_lvl};
    end
  end

  // ==========================================
  // Code group capture on the recovered clock
  brof_grp_t grp_q;
  logic grp_new_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp_q <= '0;
      grp_new_q <= 1'b0;
    end else begin
      grp_new_q <= rec_rise;
      if (rec_rise) begin
        grp_q <= brof_grp_t'(sync2_q[13:0]);
      end
    end
  end

  // ==========================================
  // 8B/10B decode with running disparity
  logic [5:0] c6, d6;
  logic [3:0] c4, d4;
  logic rd_q, rd6, rd_d, code_err, disp_err, is_k, is_comma;
  logic [7:0] dec_byte;

  assign c6 = grp_q.code[9:4];
  // K28 with positive disparity carries an inverted trailing nibble
  assign c4 = (c6 == 6'b110000) ? ~grp_q.code[3:0] : grp_q.code[3:0];
  assign d6 = dec6(c6);
  assign d4 = dec4(c4);
  assign dec_byte = {d4[2:0], d6[4:0]};

  always_comb begin
    code_err = ~d6[5] | ~d4[5 - 2];
    disp_err = 1'b0;
    rd6 = rd_q;
    if (($countones(c6) == 4 && rd_q) || ($countones(c6) == 2 && !rd_q)) begin
      disp_err = 1'b1;
    end
    if ($countones(c6) != 3) begin
      rd6 = ~rd_q;
    end
    rd_d = rd6;
    if (($countones(grp_q.code[3:0]) == 3 && rd6) ||
        ($countones(grp_q.code[3:0]) == 1 && !rd6)) begin
      disp_err = 1'b1;
    end
    if ($countones(grp_q.code[3:0]) != 2) begin
      rd_d = ~rd6;
    end
  end

  assign is_k = (c6 == 6'b001111) || (c6 == 6'b110000) ||
                ((d4[2:0] == 3'd7) && (c4 == 4'b0111 || c4 == 4'b1000) &&
                 (d6[4:0] == 5'd23 || d6[4:0] == 5'd27 ||
                  d6[4:0] == 5'd29 || d6[4:0] == 5'd30));
  assign is_comma = (grp_q.code == 10'b0011111001) || (grp_q.code == 10'b1100000110) ||
                    (grp_q.code == 10'b0011111010) || (grp_q.code == 10'b1100000101) ||
                    (grp_q.code == 10'b0011111000) || (grp_q.code == 10'b1100000111);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 1'b0;
    end else if (grp_new_q && !ctrl_q.tbs) begin
      rd_q <= rd_d;
    end
  end

  // ==========================================
  // Formatting with prioritised status codes
  brof_word_t fw, fmt_q;
  logic [7:0] ecode;
  logic ehit, dhit;

  always_comb begin
    evt_d = '0;
    evt_d.bsync = ~grp_q.bsync;
    evt_d.wsync = grp_q.bsync & ~grp_q.wsync;
    evt_d.ovr = grp_q.ovr;
    evt_d.und = grp_q.und;
    evt_d.code = ~ctrl_q.tbs & code_err;
    evt_d.disp = ~ctrl_q.tbs & disp_err & ~code_err;
    ehit = 1'b1;
    dhit = 1'b0;
    ecode = `BROF_ERR_BSYNC;
    if (!grp_q.bsync) begin
      ecode = `BROF_ERR_BSYNC;
    end else if (!grp_q.wsync) begin
      ecode = `BROF_ERR_WSYNC;
    end else if (grp_q.ovr) begin
      ecode = `BROF_ERR_OVR;
    end else if (grp_q.und) begin
      ecode = `BROF_ERR_UND;
    end else if (evt_d.code) begin
      ecode = `BROF_ERR_CODE;
      dhit = 1'b1;
    end else if (evt_d.disp) begin
      ecode = `BROF_ERR_DISP;
      dhit = 1'b1;
    end else begin
      ehit = 1'b0;
    end
    fw = '0;
    if (ctrl_q.eth || !ctrl_q.enable) begin
      fw.err = 1'b1;
      fw.data = `BROF_ERR_BSYNC;
    end else if (ctrl_q.tbs) begin
      if (ehit && !dhit) begin
        fw.k = 1'b1;
        fw.data = ecode;
      end else begin
        {fw.err, fw.dv, fw.data} = grp_q.code;
        fw.comma = is_comma;
      end
    end else if (ehit) begin
      fw.err = 1'b1;
      fw.data = ecode;
    end else begin
      fw.dv = 1'b1;
      fw.k = is_k;
      fw.comma = is_k & is_comma;
      fw.data = dec_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_q <= '0;
      fmt_q.err <= 1'b1;
    end else if (grp_new_q) begin
      fmt_q <= fw;
    end
  end

  // ==========================================
  // Output phases, single and double rate
  brof_phase_t ph_q;
  brof_word_t out_q, hold_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= BROF_PH_IDLE;
    end else begin
      case (ph_q)
        BROF_PH_IDLE, BROF_PH_FALL: begin
          if (sel_rise) begin
            ph_q <= BROF_PH_RISE;
          end
        end
        BROF_PH_RISE: begin
          if (sel_fall) begin
            ph_q <= BROF_PH_FALL;
          end
        end
        default: ph_q <= BROF_PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= '0;
      out_q <= '0;
      out_q.err <= 1'b1;
    end else if (sel_rise) begin
      hold_q <= fmt_q;
      out_q <= fmt_q;
      if (ctrl_q.ddr) begin
        out_q.err <= 1'b0;
        out_q.data <= {4'h0, fmt_q.data[3:0]};
        out_q.dv <= ctrl_q.tbs ? fmt_q.data[4] : fmt_q.dv;
      end
    end else if (sel_fall && ctrl_q.ddr && ph_q == BROF_PH_RISE) begin
      if (ctrl_q.tbs) begin
        out_q.data <= {4'h0, hold_q.dv, hold_q.data[7:5]};
        out_q.dv <= hold_q.err;
      end else begin
        out_q.data <= {4'h0, hold_q.data[7:4]};
        out_q.dv <= hold_q.err ^ hold_q.dv;
      end
    end
  end

  // ==========================================
  // APB slave, no wait states, ready in the first access cycle
  logic setup, hit;
  logic [31:0] rd_mux;

  assign setup = psel & ~penable & ~pready_q;
  assign wr_acc = psel & penable & pready_q & pwrite;

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `BROF_CTRL_OFF: rd_mux = {27'h0, ctrl_q};
      `BROF_STAT_OFF: rd_mux = {26'h0, stat_q};
      `BROF_MASK_OFF: rd_mux = {26'h0, mask_q};
      `BROF_LAST_OFF: rd_mux = {18'h0, grp_q.bsync, grp_q.wsync, fmt_q};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= brof_ctrl_t'(`BROF_CTRL_RST);
      mask_q <= '0;
    end else if (wr_acc) begin
      if (paddr == `BROF_CTRL_OFF) begin
        ctrl_q <= brof_ctrl_t'(pwdata[4:0]);
      end
      if (paddr == `BROF_MASK_OFF) begin
        mask_q <= brof_evt_t'(pwdata[5:0]);
      end
    end
  end

  // Sticky events: a new event beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((wr_acc && paddr == `BROF_STAT_OFF) ?
                            brof_evt_t'(pwdata[5:0]) : brof_evt_t'(6'h00))) |
                ((grp_new_q && ctrl_q.enable && !ctrl_q.eth) ? evt_d : brof_evt_t'(6'h00));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // ==========================================
  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign rx_output_clock = lag_q[`BROF_RCLK_LAG-1];
  assign rx_error_flag = out_q.err;
  assign rx_valid_flag = out_q.dv;
  assign rx_special_flag = out_q.k;
  assign rx_comma_flag = out_q.comma;
  assign rx_data_lines = out_q.data;

endmodule
`default_nettype wire

// *** dv/brof_formatter_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module brof_formatter_monitor
  import brof_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic rx_output_clock,
  input wire logic rx_error_flag,
  input wire logic rx_valid_flag,
  input wire logic rx_special_flag,
  input wire logic rx_comma_flag,
  input wire logic [7:0] rx_data_lines
);
  brof_ctrl_t m_q;
  logic [5:0] q_q;
  logic st, by, tn;
  // ==========================================
  // Mode seen on the bus, trusted once settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_q <= 5'h18;
      q_q <= 6'h00;
    end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
      m_q <= pwdata[4:0];
      q_q <= 6'h00;
    end else if (q_q != 6'h3f) begin
      q_q <= q_q + 6'h01;
    end
  end
  assign st = q_q == 6'h3f && m_q.enable && !m_q.eth;
  assign by = st && !m_q.tbs && !m_q.ddr;
  assign tn = st && m_q.tbs && !m_q.ddr;
  // ==========================================
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_nodv; by |-> rx_error_flag || rx_valid_flag; endproperty
  a_nodv: assert property (p_nodv) else $error("error and valid both low");
  property p_chg; by && $changed({rx_error_flag, rx_valid_flag, rx_data_lines})
    |-> ##[1:4] $rose(rx_output_clock); endproperty
  a_chg: assert property (p_chg) else $error("output not clocked");
  property p_ddr; st && m_q.ddr |-> rx_data_lines[7:4] == 4'h0; endproperty
  a_ddr: assert property (p_ddr) else $error("upper lines used");
  property p_berr; by && rx_error_flag
    |-> rx_data_lines inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10}; endproperty
  a_berr: assert property (p_berr) else $error("bad byte error code");
  property p_terr; tn && rx_special_flag
    |-> rx_data_lines inside {8'h00, 8'h01, 8'h02, 8'h04}; endproperty
  a_terr: assert property (p_terr) else $error("bad ten-bit code");
  property p_tcom; tn && rx_comma_flag |-> !rx_special_flag &&
    {rx_error_flag, rx_valid_flag, rx_data_lines} inside
    {10'h0f9, 10'h306, 10'h0fa, 10'h305, 10'h0f8, 10'h307}; endproperty
  a_tcom: assert property (p_tcom) else $error("bad comma");
  property p_bcom; by && !rx_error_flag && rx_comma_flag
    |-> rx_special_flag && rx_data_lines inside {8'h3c, 8'hbc, 8'hfc}; endproperty
  a_bcom: assert property (p_bcom) else $error("bad byte comma");
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not one pulse");
endmodule
bind brof_formatter brof_formatter_monitor mon_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .rx_output_clock, .rx_error_flag, .rx_valid_flag,
  .rx_special_flag, .rx_comma_flag, .rx_data_lines);
`default_nettype wire

// *** dv/brof_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module brof_host_model
  import brof_pkg::*;
(
  input wire logic rx_output_clock,
  input wire logic ddr,
  input wire logic tbs,
  input wire brof_word_t lines,
  output var brof_word_t word
);
  brof_word_t r_q;
  // ==========================================
  // Rising half held, word rebuilt at fall
  always @(posedge rx_output_clock) r_q <= lines;
  always @(negedge rx_output_clock) begin
    if (!ddr) begin
      word <= r_q;
    end else if (tbs) begin
      word <= {lines.dv, lines.data[3], r_q.k, r_q.comma, lines.data[2:0], r_q.dv,
        r_q.data[3:0]};
    end else begin
      word <= {lines.dv ^ r_q.dv, r_q.dv, r_q.k, r_q.comma, lines.data[3:0],
        r_q.data[3:0]};
    end
  end
endmodule
`default_nettype wire

// *** dv/brof_formatter_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module brof_formatter_tb_top
  import brof_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic rc = 1'b0, fc = 1'b0, pready, pslverr, irq, oc, se;
  logic [3:0] fl = 4'hc;
  logic [9:0] cg = 10'h2aa;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  wire brof_word_t ol;
  brof_word_t hw;
  brof_ctrl_t ct = 5'h18;
  logic [9:0] tc [10];
  logic [11:0] tw [10];
  logic [23:0] q [3];
  int n_mismatch = 0, checked = 0, cyc = 0, seed = 30, nv = 0;
  always #2 pclk = ~pclk;
  initial begin
    #5;
    forever #32 rc = ~rc;
  end
  initial begin
    #9;
    forever #48 fc = ~fc;
  end
  brof_formatter dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .rx_rec_clk(rc), .rx_ref_clk(fc), .rx_code_group(cg), .rx_byte_sync(fl[3]),
    .rx_word_sync(fl[2]), .rx_overrun(fl[1]), .rx_underrun(fl[0]), .rx_output_clock(oc),
    .rx_error_flag(ol.err), .rx_valid_flag(ol.dv), .rx_special_flag(ol.k),
    .rx_comma_flag(ol.comma), .rx_data_lines(ol.data)
  );
  brof_host_model host_u (.rx_output_clock(oc), .ddr(ct.ddr), .tbs(ct.tbs), .lines(ol),
    .word(hw));
  // ==========================================
  // Checking and closing
  task automatic tally_and_finish();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, s, m);
    checked++;
    if ((e & m) !== (s & m)) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e & m, s & m);
    end
  endtask
  function automatic logic cm(input logic [9:0] c);
    return c inside {10'h0f9, 10'h306, 10'h0fa, 10'h305, 10'h0f8, 10'h307};
  endfunction
  // Expected host word: mask in the upper half, value in the lower
  function automatic logic [23:0] fx(input logic [9:0] c, input logic [3:0] f,
    input logic [11:0] bw);
    logic [7:0] e;
    logic bad;
    bad = !f[3] || !f[2] || f[1] || f[0];
    e = !f[3] ? 8'h00 : !f[2] ? 8'h01 : f[1] ? 8'h04 : 8'h02;
    if (ct.eth || !ct.enable) return {12'h8ff, 12'h800};
    if (ct.tbs && bad) return {12'h2ff, 4'h2, e};
    if (ct.tbs) return {12'hfff, c[9:8], 1'b0, cm(c), c[7:0]};
    if (bad) return {12'h8ff, 4'h8, e};
    return {bw[11] ? 12'h8ff : bw[9] ? 12'hfff : 12'heff, bw};
  endfunction
  // ==========================================
  // Bus and link drivers
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // The host shows the group sent three calls earlier
  task automatic send(input logic [9:0] c, input logic [3:0] f, input logic [11:0] bw);
    @(negedge rc);
    @(posedge pclk);
    if (nv >= 3) chk("word", q[2][11:0], hw, q[2][23:12]);
    q[2] = q[1];
    q[1] = q[0];
    q[0] = fx(c, f, bw);
    cg <= c;
    fl <= f;
    nv++;
  endtask
  task automatic run(input logic [4:0] m);
    logic [3:0] f;
    apb(1'b1, 12'h000, {27'h0, m});
    ct = m;
    nv = 0;
    for (int i = 0; i < 50; i++) begin
      f = i < 10 ? 4'hc : 4'($random(seed));
      if (!m[0] && i >= 10 && f == 4'hc) f = 4'hd;
      send(i < 10 ? tc[i] : 10'($random(seed)), f, i < 10 ? tw[i] : 12'h000);
    end
  endtask
  task automatic per(input int p);
    time t;
    // First rise after a source switch may be a switch artefact
    repeat (2) @(posedge oc);
    t = $time;
    repeat (4) @(posedge oc);
    chk("period", 1, ($time - t) >= 4 * p - 4 && ($time - t) <= 4 * p + 4, 1);
  endtask
  initial begin
    tc = '{10'h0fa, 10'h305, 10'h2aa, 10'h274, 10'h0f4, 10'h0f9, 10'h306, 10'h0f8,
      10'h305, 10'h000};
    tw = '{12'h7bc, 12'h7bc, 12'h4b5, 12'h400, 12'h61c, 12'h73c, 12'h73c, 12'h7fc,
      12'h810, 12'h808};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h18, rd, 32'hffffffff);
    apb(1'b0, 12'h008, 32'h0);
    chk("mask", 32'h0, rd, 32'hffffffff);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, se}, 32'h1);
    chk("unmapped", 32'h0, rd, 32'hffffffff);
    run(5'h18);
    presetn <= 1'b0;
    cg <= 10'h2aa;
    fl <= 4'hc;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    run(5'h1c);
    run(5'h19);
    repeat (3) send(10'h2aa, 4'hc, 12'h000);
    apb(1'b1, 12'h008, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h4, rd, 32'h4);
    apb(1'b1, 12'h008, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h004, 32'h3f);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h008, 32'h0);
    run(5'h1d);
    run(5'h1a);
    run(5'h08);
    apb(1'b1, 12'h000, 32'h10);
    per(96);
    apb(1'b1, 12'h000, 32'h18);
    per(64);
    tally_and_finish();
  end
endmodule
`default_nettype wire
